// File: tb_trg_health_gate.sv
// self-checking bench of the random number health gate
`timescale 1ns/1ps

module tb_trg_health_gate;
	import trg_pkg::*;

	// ------------------------------------------------------------
	// signals and counters
	// ------------------------------------------------------------
	logic        clk;
	logic        rst_n;
	logic        raw_bit;
	logic        raw_vld;
	logic        fail_clr;
	logic        rd_rdy;
	trg_word_t   rnd_data;
	logic        rnd_vld;
	logic        stat_ok;
	logic        fail_sticky;
	int          fail_count;
	int          n_tests;

	trg_health_gate dut (
		.CLK_I        (clk),
		.RESETN_I     (rst_n),
		.RAW_BIT_I    (raw_bit),
		.RAW_VALID_I  (raw_vld),
		.FAIL_CLR_I   (fail_clr),
		.RND_READY_I  (rd_rdy),
		.RND_DATA_O   (rnd_data),
		.RND_VALID_O  (rnd_vld),
		.STAT_OK_O    (stat_ok),
		.FAIL_STICKY_O(fail_sticky)
	);

	// 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	task automatic chk_word(input trg_word_t got, input trg_word_t exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	// one raw bit, taken at the following edge; calls run back to back
	task automatic bitx(input logic b);
		@(posedge clk);
		raw_bit <= b;
		raw_vld <= 1'b1;
	endtask

	task automatic idle;
		@(posedge clk);
		raw_vld <= 1'b0;
	endtask

	// settle point: n edges on, then the falling edge
	task automatic look(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic clear;
		@(posedge clk);
		fail_clr <= 1'b1;
		@(posedge clk);
		fail_clr <= 1'b0;
		look(1);
	endtask

	// balanced stream, no runs, half ones
	task automatic alt(input int n);
		for (int i = 0; i < n; i++) begin
			bitx(i % 2 == 0);
		end
	endtask

	// msb first; pair 0,1 xors to one and 1,1 to zero
	task automatic send_word(input trg_word_t w);
		for (int i = 31; i >= 0; i--) begin
			bitx(!w[i]);
			bitx(1'b1);
		end
		idle;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_zero_run;
		repeat (31) bitx(1'b0);
		idle;
		look(1);
		chk_bit(fail_sticky, 1'b0, "31 zeros flagged");
		// a clear sampled with the failing bit must lose to the set
		bitx(1'b0);
		fail_clr <= 1'b1;
		idle;
		fail_clr <= 1'b0;
		look(1);
		chk_bit(fail_sticky, 1'b1, "32 zeros not flagged");
		chk_bit(stat_ok, 1'b0, "open after total failure");
	endtask

	task automatic t_startup;
		clear;
		chk_bit(fail_sticky, 1'b0, "sticky not cleared");
		alt(1023);
		idle;
		look(1);
		chk_bit(stat_ok, 1'b0, "open before window end");
		chk_bit(rnd_vld, 1'b0, "word before start-up pass");
		alt(1);
		idle;
		look(1);
		chk_bit(stat_ok, 1'b1, "closed after good window");
	endtask

	// reader stalls, two words wait in the buffer
	task automatic t_words;
		send_word(32'hA5C3_0F96);
		look(1);
		chk_bit(rnd_vld, 1'b1, "no word after 64 bits");
		chk_word(rnd_data, 32'hA5C3_0F96, "first word");
		send_word(32'h5A3C_F069);
		look(1);
		chk_word(rnd_data, 32'hA5C3_0F96, "head lost in stall");
		@(posedge clk);
		rd_rdy <= 1'b1;
		@(posedge clk);
		rd_rdy <= 1'b0;
		@(negedge clk);
		chk_bit(rnd_vld, 1'b1, "second word missing");
		chk_word(rnd_data, 32'h5A3C_F069, "second word");
		// a clear while running touches only the sticky flag
		clear;
		chk_bit(stat_ok, 1'b1, "clear restarted a running gate");
		chk_bit(rnd_vld, 1'b1, "clear dropped a waiting word");
	endtask

	// long run of ones while a word is buffered
	task automatic t_fail_run;
		repeat (32) bitx(1'b1);
		idle;
		look(1);
		chk_bit(fail_sticky, 1'b1, "run failure missed");
		chk_bit(stat_ok, 1'b0, "open after run failure");
		chk_bit(rnd_vld, 1'b0, "buffered word not flushed");
		chk_word(rnd_data, 32'h0000_0000, "flushed word still visible");
	endtask

	// restart, then a window with 683 ones
	task automatic t_window_fail;
		clear;
		chk_bit(stat_ok, 1'b0, "open right after restart");
		for (int i = 0; i < 1024; i++) begin
			bitx(i % 3 != 2);
		end
		idle;
		look(1);
		chk_bit(fail_sticky, 1'b1, "biased window missed");
		chk_bit(stat_ok, 1'b0, "open after biased window");
	endtask

	// restart, then a biased window while open; the reader stalls throughout
	task automatic t_run_window;
		clear;
		alt(1024);
		idle;
		look(1);
		chk_bit(stat_ok, 1'b1, "closed after second good window");
		for (int i = 0; i < 1023; i++) begin
			bitx(i % 3 != 2);
		end
		idle;
		look(1);
		chk_bit(stat_ok, 1'b1, "closed before running window end");
		chk_word(rnd_data, 32'h6DB6_DB6D, "first word of biased stream");
		bitx(1'b1);
		idle;
		look(1);
		chk_bit(fail_sticky, 1'b1, "biased running window missed");
		chk_bit(rnd_vld, 1'b0, "words kept after running failure");
	endtask

	// second reset while failed: everything, the sticky flag too, returns to the start-up state
	task automatic t_reset_mid;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk_bit(fail_sticky, 1'b0, "sticky kept through reset");
		chk_bit(stat_ok, 1'b0, "open after second reset");
		chk_bit(rnd_vld, 1'b0, "word offered after second reset");
		chk_word(rnd_data, 32'h0000_0000, "data after second reset");
	endtask

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		fail_count = 0;
		n_tests = 0;
		rst_n = 1'b0;
		raw_bit = 1'b0;
		raw_vld = 1'b0;
		fail_clr = 1'b0;
		rd_rdy = 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk_word(rnd_data, 32'h0000_0000, "data after reset");
		chk_bit(stat_ok, 1'b0, "open after reset");
		t_zero_run;
		t_startup;
		t_words;
		t_fail_run;
		t_window_fail;
		t_run_window;
		t_reset_mid;
		finish_test;
	end

	// full run is near 4400 cycles; this allows about twice that
	initial begin
		#1_000_000;
		fail_count++;
		finish_test;
	end

endmodule

// File: trg_buf.sv
// two-entry output buffer with flush
`timescale 1ns/1ps

module trg_buf
	import trg_pkg::*;
(
	input  wire logic  clk_i,
	input  wire logic  rst_n_i,
	trg_stream_if.snk  in_if,
	output trg_word_t  dout_o,
	output logic       vld_o,
	input  wire logic  rdy_i
);

	localparam trg_buf_t RST = '{mem: '0, wr_idx: 1'b0, rd_idx: 1'b0, cnt: 2'h0,
		vld: 1'b0, rdy: 1'b1, dout: '0};

	trg_buf_t q;
	trg_buf_t n;
	logic     push;
	logic     pop;

	// ------------------------------------------------------------
	// next state: ready and data out are registered so the top sees flops
	// ------------------------------------------------------------
	always_comb begin
		n = q;
		pop = q.vld & rdy_i;
		push = in_if.valid & q.rdy;
		if (pop) begin
			n.rd_idx = ~q.rd_idx;
		end
		if (push) begin
			n.mem[q.wr_idx] = in_if.data;
			n.wr_idx = ~q.wr_idx;
		end
		case ({push, pop})
			2'b10:   n.cnt = q.cnt + 2'h1;
			2'b01:   n.cnt = q.cnt - 2'h1;
			default: n.cnt = q.cnt;
		endcase
		// flush drops everything, a word pushed in the same cycle too
		if (in_if.flush) begin
			n.cnt = 2'h0;
			n.rd_idx = 1'b0;
			n.wr_idx = 1'b0;
		end
		n.vld = (n.cnt != 2'h0);
		n.rdy = (n.cnt != 2'h2);
		// an empty buffer shows zeros, so a flushed word never lingers on the pins
		n.dout = n.vld ? n.mem[n.rd_idx] : '0;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= RST;
		end else begin
			q <= n;
		end
	end

	assign in_if.ready = q.rdy;
	assign vld_o = q.vld;
	assign dout_o = q.dout;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_buf_hold_word: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(vld_o && !rdy_i && !in_if.flush) |=> (vld_o && $stable(dout_o)))
		else $error("buffer dropped or changed a stalled word");
	chk_buf_full_ready: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(q.cnt == 2'h2) |-> !in_if.ready)
		else $error("buffer ready while full");

endmodule

// File: trg_defs.svh
// constants of the random number health gate
`ifndef TRG_DEFS_SVH
`define TRG_DEFS_SVH

// ------------------------------------------------------------
// word width and last bit index
// ------------------------------------------------------------
`define TRG_WORD_W    32
`define TRG_IDX_LAST  5'h1f

// ------------------------------------------------------------
// health test limits
// ------------------------------------------------------------
`define TRG_REP_LIMIT 6'h20
`define TRG_WIN_LAST  10'h3ff
`define TRG_ONES_MIN  11'h1b0
`define TRG_ONES_MAX  11'h250

`endif

// File: trg_health_gate.sv
// health supervision and output gating of a physical random bit source
`timescale 1ns/1ps

`include "trg_defs.svh"

module trg_health_gate
	import trg_pkg::*;
(
	input  wire logic                  CLK_I,
	input  wire logic                  RESETN_I,
	input  wire logic                  RAW_BIT_I,
	input  wire logic                  RAW_VALID_I,
	input  wire logic                  FAIL_CLR_I,
	input  wire logic                  RND_READY_I,
	output logic [`TRG_WORD_W-1:0]     RND_DATA_O,
	output logic                       RND_VALID_O,
	output logic                       STAT_OK_O,
	output logic                       FAIL_STICKY_O
);

	localparam trg_gate_t RST = '{st: TRG_ST_STARTUP, last_bit: 1'b0, rep_cnt: 6'h00,
		win_cnt: 10'h000, ones_cnt: 11'h000, half: 1'b0, first_bit: 1'b0,
		bit_idx: 5'h00, word: '0, push: 1'b0, ok: 1'b0, sticky: 1'b0};

	trg_stream_if bif ();

	trg_gate_t   q;
	trg_gate_t   n;
	logic        rep_hit;
	logic        win_end;
	logic        win_bad;
	logic        fail_evt;
	logic        stall;
	logic [10:0] ones;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		n = q;
		rep_hit = 1'b0;
		win_end = 1'b0;
		win_bad = 1'b0;
		ones = q.ones_cnt + {10'h000, RAW_BIT_I};
		stall = q.push & ~bif.ready;
		// a word taken by the buffer frees the holding register first
		if (q.push && bif.ready) begin
			n.push = 1'b0;
		end
		case (q.st)
			TRG_ST_STARTUP, TRG_ST_RUN: begin
				if (RAW_VALID_I) begin
					// run length of identical bits: a stuck source is a total failure
					n.last_bit = RAW_BIT_I;
					if (RAW_BIT_I == q.last_bit) begin
						n.rep_cnt = q.rep_cnt + 6'h01;
						rep_hit = (q.rep_cnt == (`TRG_REP_LIMIT - 6'h01));
					end else begin
						n.rep_cnt = 6'h01;
					end
					// ones count over a fixed window, checked at each window end
					if (q.win_cnt == `TRG_WIN_LAST) begin
						win_end = 1'b1;
						win_bad = (ones < `TRG_ONES_MIN) || (ones > `TRG_ONES_MAX);
						n.win_cnt = 10'h000;
						n.ones_cnt = 11'h000;
						if (!win_bad && (q.st == TRG_ST_STARTUP)) begin
							n.st = TRG_ST_RUN;
							n.ok = 1'b1;
						end
					end else begin
						n.win_cnt = q.win_cnt + 10'h001;
						n.ones_cnt = ones;
					end
					// word assembly only while open; bits arriving in a stall are lost
					// on purpose, since a live noise source cannot be paused
					if ((q.st == TRG_ST_RUN) && !stall) begin
						if (!q.half) begin
							n.first_bit = RAW_BIT_I;
							n.half = 1'b1;
						end else begin
							n.half = 1'b0;
							n.word = {q.word[`TRG_WORD_W-2:0], q.first_bit ^ RAW_BIT_I};
							n.bit_idx = q.bit_idx + 5'h01;
							if (q.bit_idx == `TRG_IDX_LAST) begin
								n.push = 1'b1;
							end
						end
					end
				end
			end
			TRG_ST_FAIL: begin
				// tests stay frozen until software asks for a fresh start-up test
				if (FAIL_CLR_I) begin
					n = RST;
					n.sticky = q.sticky;
				end
			end
			default: begin
				n.st = TRG_ST_FAIL;
				n.ok = 1'b0;
			end
		endcase
		fail_evt = rep_hit | (win_end & win_bad);
		// any failure closes the output and discards the unfinished word
		if (fail_evt) begin
			n.st = TRG_ST_FAIL;
			n.ok = 1'b0;
			n.push = 1'b0;
			n.half = 1'b0;
			n.bit_idx = 5'h00;
		end
		// set wins over a clear in the same cycle
		n.sticky = fail_evt | (q.sticky & ~FAIL_CLR_I);
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			q <= RST;
		end else begin
			q <= n;
		end
	end

	// ------------------------------------------------------------
	// output buffer: flush on failure drops the words still waiting; words read out before the failure cycle, even from the failing window, have left
	// ------------------------------------------------------------
	assign bif.data = q.word;
	assign bif.valid = q.push;
	assign bif.flush = fail_evt;

	trg_buf u_buf (
		.clk_i   (CLK_I),
		.rst_n_i (RESETN_I),
		.in_if   (bif),
		.dout_o  (RND_DATA_O),
		.vld_o   (RND_VALID_O),
		.rdy_i   (RND_READY_I)
	);

	assign STAT_OK_O = q.ok;
	assign FAIL_STICKY_O = q.sticky;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);

	// a stuck source closes the gate at once
	chk_rep_to_fail: assert property (rep_hit |=> (q.st == TRG_ST_FAIL) && !STAT_OK_O)
		else $error("repetition failure did not close the gate");

	// only a restart request leaves the failed state
	chk_fail_holds: assert property ((q.st == TRG_ST_FAIL) && !FAIL_CLR_I |=>
		(q.st == TRG_ST_FAIL) && !STAT_OK_O)
		else $error("gate left the failed state without a restart");

	// buffered words are thrown away with the failure
	chk_fail_flushes_out: assert property (fail_evt |=> !RND_VALID_O)
		else $error("words still offered after a failure");

	// the half-built word goes too, so no later word mixes bits from both sides
	chk_fail_drops_word: assert property (fail_evt |=>
		!bif.valid && !q.half && (q.bit_idx == 5'h00))
		else $error("partial word survived a failure");

	// a bad window is a defect whether met at start-up or while running
	chk_win_to_fail: assert property ((win_end && win_bad) |=> q.st == TRG_ST_FAIL)
		else $error("bad window did not close the gate");

	// nothing enters the buffer unless the gate is running
	chk_no_push_closed: assert property ((q.st != TRG_ST_RUN) |-> !bif.valid)
		else $error("word pushed while gate closed");

	// start-up shows neither status nor words; the failure flush emptied the buffer
	chk_startup_closed: assert property ((q.st == TRG_ST_STARTUP) |->
		!STAT_OK_O && !RND_VALID_O)
		else $error("output open during start-up test");

	// a clear while running only touches the sticky flag
	chk_clear_keeps_run: assert property ((q.st == TRG_ST_RUN) && FAIL_CLR_I && !fail_evt
		|=> (q.st == TRG_ST_RUN) && STAT_OK_O)
		else $error("clear disturbed a running gate");

	// the gate opens only at the end of a passing window
	chk_open_after_win: assert property ($rose(STAT_OK_O) |->
		($past(win_end) && !$past(win_bad)))
		else $error("gate opened without a passing window");

	// a word leaves the assembler only when all 32 output bits are in
	chk_word_full: assert property ($rose(q.push) |-> $past(q.bit_idx) == `TRG_IDX_LAST)
		else $error("word pushed before 32 bits");

	// a finished word waits unchanged while the buffer is full
	chk_full_word_held: assert property (bif.valid && !bif.ready && !fail_evt |=>
		bif.valid && $stable(bif.data))
		else $error("waiting word changed or vanished");

	// every output bit is the xor of one raw pair
	chk_pair_xor: assert property ((q.st == TRG_ST_RUN) && RAW_VALID_I && q.half
		&& !stall && !fail_evt |=> q.word[0] == ($past(q.first_bit) ^ $past(RAW_BIT_I)))
		else $error("output bit is not the xor of a raw pair");

	// the flag is raised by every failure, even against a clear in the same cycle
	chk_sticky_set: assert property (fail_evt |=> FAIL_STICKY_O)
		else $error("sticky flag not set by failure");

	// once raised, the flag stays until a clear
	chk_sticky_hold: assert property (FAIL_STICKY_O && !FAIL_CLR_I |=> FAIL_STICKY_O)
		else $error("sticky flag dropped without a clear");

	// the status pin never claims validity outside normal running
	chk_ok_only_run: assert property (STAT_OK_O |-> q.st == TRG_ST_RUN)
		else $error("status open outside normal running");

	// ------------------------------------------------------------
	// coverage of the main scenarios
	// ------------------------------------------------------------
	cov_startup_pass: cover property ($rose(STAT_OK_O));
	cov_word_out: cover property (RND_VALID_O && RND_READY_I);
	cov_rep_fail: cover property (rep_hit);
	cov_run_win_fail: cover property ((q.st == TRG_ST_RUN) && win_end && win_bad);
	cov_restart: cover property ((q.st == TRG_ST_FAIL) && FAIL_CLR_I);

endmodule

// File: trg_pkg.sv
// types shared by the random number health gate
`include "trg_defs.svh"

package trg_pkg;

	// ------------------------------------------------------------
	// gate state machine
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		TRG_ST_STARTUP,
		TRG_ST_RUN,
		TRG_ST_FAIL
	} trg_state_t;

	typedef logic [`TRG_WORD_W-1:0] trg_word_t;

	// ------------------------------------------------------------
	// whole state of the gate
	// ------------------------------------------------------------
	typedef struct packed {
		trg_state_t  st;
		logic        last_bit;
		logic [5:0]  rep_cnt;
		logic [9:0]  win_cnt;
		logic [10:0] ones_cnt;
		logic        half;
		logic        first_bit;
		logic [4:0]  bit_idx;
		trg_word_t   word;
		logic        push;
		logic        ok;
		logic        sticky;
	} trg_gate_t;

	// ------------------------------------------------------------
	// whole state of the two-entry buffer
	// ------------------------------------------------------------
	typedef struct packed {
		trg_word_t [1:0] mem;
		logic            wr_idx;
		logic            rd_idx;
		logic [1:0]      cnt;
		logic            vld;
		logic            rdy;
		trg_word_t       dout;
	} trg_buf_t;

endpackage

// File: trg_stream_if.sv
// word stream between the gate and its output buffer
`timescale 1ns/1ps

interface trg_stream_if;
	import trg_pkg::*;
	trg_word_t data;
	logic      valid;
	logic      ready;
	logic      flush;

	modport src (output data, output valid, output flush, input ready);
	modport snk (input data, input valid, input flush, output ready);
endinterface
